// file: shared/rrs_defs.svh
// Register map, field positions, reset value and timing counts
`ifndef RRS_DEFS_SVH
`define RRS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RRS_ADDR_RAMP12 8'h47
`define RRS_ADDR_RAMP34 8'h48
`define RRS_ADDR_RAMP5L 8'h49
`define RRS_ADDR_DLY1   8'h4A
`define RRS_ADDR_DLY2   8'h4B
`define RRS_ADDR_DLY3   8'h4C
`define RRS_ADDR_DLY4   8'h4D

// ----------------------------------------------------------------
// Field positions and reset value
// ----------------------------------------------------------------
`define RRS_F_HI_MSB  7
`define RRS_F_HI_LSB  5
`define RRS_F_MID_MSB 4
`define RRS_F_MID_LSB 2
`define RRS_F_LIN_MSB 4
`define RRS_F_LIN_LSB 3
`define RRS_F_DLY_MSB 6
`define RRS_REG_RST   8'h00
`define RRS_RD_NONE   8'h00

// ----------------------------------------------------------------
// Timing: all durations are whole half milliseconds
// ----------------------------------------------------------------
`define RRS_CLK_NS      10
`define RRS_HALF_MS_NS  500000
`define RRS_HALF_MS_CYC (`RRS_HALF_MS_NS / `RRS_CLK_NS)

`endif

// file: shared/rrs_pkg.sv
// Types and ramp table decode for the rail ramp sequencer
`default_nettype none
package rrs_pkg;

  typedef enum logic [1:0] {
    RRS_IDLE,
    RRS_WAIT,
    RRS_RAMP,
    RRS_UP
  } rrs_state_e;

  typedef logic [2:0] rrs_code_t;
  typedef logic [7:0] rrs_ticks_t;

  // Ramp code to half-millisecond ticks: 0.5,1,1.5,2,4,6,8,10 ms
  function automatic rrs_ticks_t rrs_ramp_ticks(input rrs_code_t c);
    case (c)
      3'h0:    rrs_ramp_ticks = 8'h01;
      3'h1:    rrs_ramp_ticks = 8'h02;
      3'h2:    rrs_ramp_ticks = 8'h03;
      3'h3:    rrs_ramp_ticks = 8'h04;
      3'h4:    rrs_ramp_ticks = 8'h08;
      3'h5:    rrs_ramp_ticks = 8'h0C;
      3'h6:    rrs_ramp_ticks = 8'h10;
      default: rrs_ramp_ticks = 8'h14;
    endcase
  endfunction

endpackage
`default_nettype wire

// file: shared/rrs_if.sv
// Control link between the top and one rail sequencer
`timescale 1ns/1ps
`default_nettype none
interface rrs_if;
  logic       tick;
  logic       start;
  logic       pg;
  logic [6:0] delay;
  logic [2:0] code;
  logic       en;
  logic       busy;
  logic       done;

  modport ctl (output tick, start, pg, delay, code,
               input  en, busy, done);
  modport seq (input  tick, start, pg, delay, code,
               output en, busy, done);
endinterface
`default_nettype wire

// file: src/rrs_rail_seq.sv
// Per-rail start wait and soft-start ramp sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rrs_defs.svh"
module rrs_rail_seq
  import rrs_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control link
  rrs_if.seq        ctl
);

  rrs_state_e st_r;
  rrs_state_e st_nxt;
  rrs_ticks_t cnt_r;
  rrs_ticks_t cnt_nxt;
  rrs_ticks_t dly_r;
  rrs_ticks_t rlen_r;
  logic       en_r;
  logic       busy_r;
  logic       done_r;

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      RRS_IDLE: begin
        if (ctl.start) begin
          st_nxt  = RRS_WAIT;
          cnt_nxt = 8'h00;
        end
      end
      RRS_WAIT: begin
        if (cnt_r == dly_r) begin // RULE_07 RULE_08
          st_nxt  = RRS_RAMP;
          cnt_nxt = 8'h00;
        end else if (ctl.tick) begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      RRS_RAMP: begin
        if (cnt_r == rlen_r) begin // RULE_09
          st_nxt = RRS_UP;
        end else if (ctl.tick) begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      default: begin
      end
    endcase
    // Losing power good aborts the sequence from any state
    if (!ctl.pg) begin
      st_nxt  = RRS_IDLE;
      cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r  <= RRS_IDLE;
      cnt_r <= 8'h00;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Delay is latched at start and the ramp code at ramp start, so a later write cannot stretch either
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_r  <= 8'h00;
      rlen_r <= 8'h01;
    end else begin
      if (st_r == RRS_IDLE && ctl.start) begin
        dly_r <= {ctl.delay, 1'b0}; // RULE_08
      end
      if (st_r == RRS_WAIT && st_nxt == RRS_RAMP) begin
        rlen_r <= rrs_ramp_ticks(ctl.code); // RULE_09
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r   <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      en_r   <= (st_nxt == RRS_RAMP) || (st_nxt == RRS_UP);
      busy_r <= (st_nxt == RRS_RAMP);
      done_r <= (st_nxt == RRS_UP);
    end
  end

  assign ctl.en   = en_r;
  assign ctl.busy = busy_r;
  assign ctl.done = done_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_zero_delay: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    st_r == RRS_WAIT && dly_r == 8'h00 && ctl.pg |=> st_r == RRS_RAMP)
    else $error("zero delay did not start ramp");

  a_wait_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    st_r == RRS_WAIT && cnt_r != dly_r && ctl.pg |=> st_r == RRS_WAIT)
    else $error("wait left before delay expired");

  a_ramp_end: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    st_r == RRS_RAMP && cnt_r == rlen_r && ctl.pg |=> done_r && !busy_r)
    else $error("ramp did not finish on length");

  a_pg_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl.pg |=> st_r == RRS_IDLE && !en_r)
    else $error("rail stayed on without power good");

endmodule
`default_nettype wire

// file: src/rrs_top.sv
// Rail ramp time and start delay configuration with sequencing
//
// What this block does
// [RULE_01] Rail one ramp time is code bits 7:5 of 0x47, 0.5 to 10 ms.
// [RULE_02] Rail two ramp time is code bits 4:2 of 0x47, same table.
// [RULE_03] Rail three ramp time is code bits 7:5 of 0x48, same table.
// [RULE_04] Rail four ramp time is code bits 4:2 of 0x48, same table.
// [RULE_05] Rail five ramp time is code bits 7:5 of 0x49, same table.
// [RULE_06] Linear regulator ramp is bits 4:3 of 0x49: 100/200/500us,1ms.
// [RULE_07] Rails one to four hold a 7-bit start wait at 0x4A to 0x4D.
// [RULE_08] Each start wait counts whole milliseconds from 0 to 127.
// [RULE_09] When a wait expires the rail ramps for its selected time.
// [RULE_10] Reserved bits store and read back with no effect on timing.
`timescale 1ns/1ps
`default_nettype none
`include "rrs_defs.svh"
module rrs_top
  import rrs_pkg::*;
#(
  parameter int HALF_MS_CYC = `RRS_HALF_MS_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  // System power good pin
  input  wire logic       pg_i,
  // Ramp selections to the regulators
  output logic      [2:0] ramp_duration_rail_one_o,
  output logic      [2:0] ramp_duration_rail_two_o,
  output logic      [2:0] ramp_duration_rail_three_o,
  output logic      [2:0] ramp_duration_rail_four_o,
  output logic      [2:0] ramp_duration_rail_five_o,
  output logic      [1:0] ramp_duration_linear_reg_o,
  // Rail sequence status, bit 0 is rail one
  output logic      [3:0] rail_en_o,
  output logic      [3:0] rail_ramping_o,
  output logic      [3:0] rail_up_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ramp_time_rails_one_two_r;
  logic [7:0] ramp_time_rails_three_four_r;
  logic [7:0] ramp_time_rail_five_linear_r;
  logic [7:0] start_delay_r [4];
  logic [7:0] rdata_nxt;

  // Whole bytes are kept, reserved bits included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_time_rails_one_two_r    <= `RRS_REG_RST;
      ramp_time_rails_three_four_r <= `RRS_REG_RST;
      ramp_time_rail_five_linear_r <= `RRS_REG_RST;
      for (int i = 0; i < 4; i++) begin
        start_delay_r[i] <= `RRS_REG_RST;
      end
    end else if (reg_we_i) begin
      if (reg_addr_i == `RRS_ADDR_RAMP12) begin
        ramp_time_rails_one_two_r <= reg_wdata_i; // RULE_01 RULE_02 RULE_10
      end else if (reg_addr_i == `RRS_ADDR_RAMP34) begin
        ramp_time_rails_three_four_r <= reg_wdata_i; // RULE_03 RULE_04
      end else if (reg_addr_i == `RRS_ADDR_RAMP5L) begin
        ramp_time_rail_five_linear_r <= reg_wdata_i; // RULE_05 RULE_06
      end else if (reg_addr_i == `RRS_ADDR_DLY1) begin
        start_delay_r[0] <= reg_wdata_i; // RULE_07
      end else if (reg_addr_i == `RRS_ADDR_DLY2) begin
        start_delay_r[1] <= reg_wdata_i; // RULE_07
      end else if (reg_addr_i == `RRS_ADDR_DLY3) begin
        start_delay_r[2] <= reg_wdata_i; // RULE_07
      end else if (reg_addr_i == `RRS_ADDR_DLY4) begin
        start_delay_r[3] <= reg_wdata_i; // RULE_07
      end
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb begin
    if (reg_addr_i == `RRS_ADDR_RAMP12) begin
      rdata_nxt = ramp_time_rails_one_two_r; // RULE_10
    end else if (reg_addr_i == `RRS_ADDR_RAMP34) begin
      rdata_nxt = ramp_time_rails_three_four_r;
    end else if (reg_addr_i == `RRS_ADDR_RAMP5L) begin
      rdata_nxt = ramp_time_rail_five_linear_r;
    end else if (reg_addr_i == `RRS_ADDR_DLY1) begin
      rdata_nxt = start_delay_r[0];
    end else if (reg_addr_i == `RRS_ADDR_DLY2) begin
      rdata_nxt = start_delay_r[1];
    end else if (reg_addr_i == `RRS_ADDR_DLY3) begin
      rdata_nxt = start_delay_r[2];
    end else if (reg_addr_i == `RRS_ADDR_DLY4) begin
      rdata_nxt = start_delay_r[3];
    end else begin
      rdata_nxt = `RRS_RD_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o  <= `RRS_RD_NONE;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_re_i;
      if (reg_re_i) begin
        reg_rdata_o <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ramp selections out
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_duration_rail_one_o   <= 3'h0;
      ramp_duration_rail_two_o   <= 3'h0;
      ramp_duration_rail_three_o <= 3'h0;
      ramp_duration_rail_four_o  <= 3'h0;
      ramp_duration_rail_five_o  <= 3'h0;
      ramp_duration_linear_reg_o <= 2'h0;
    end else begin
      ramp_duration_rail_one_o <=
        ramp_time_rails_one_two_r[`RRS_F_HI_MSB:`RRS_F_HI_LSB]; // RULE_01
      ramp_duration_rail_two_o <=
        ramp_time_rails_one_two_r[`RRS_F_MID_MSB:`RRS_F_MID_LSB]; // RULE_02
      ramp_duration_rail_three_o <=
        ramp_time_rails_three_four_r[`RRS_F_HI_MSB:`RRS_F_HI_LSB]; // RULE_03
      ramp_duration_rail_four_o <=
        ramp_time_rails_three_four_r[`RRS_F_MID_MSB:`RRS_F_MID_LSB]; // RULE_04
      ramp_duration_rail_five_o <=
        ramp_time_rail_five_linear_r[`RRS_F_HI_MSB:`RRS_F_HI_LSB]; // RULE_05
      ramp_duration_linear_reg_o <=
        ramp_time_rail_five_linear_r[`RRS_F_LIN_MSB:`RRS_F_LIN_LSB]; // RULE_06
    end
  end

  // ----------------------------------------------------------------
  // Power good sync and half-millisecond tick
  // ----------------------------------------------------------------
  logic        pg_s1_r;
  logic        pg_s2_r;
  logic        pg_d_r;
  logic        start_w;
  logic [15:0] div_r;
  logic        tick_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pg_s1_r <= 1'b0;
      pg_s2_r <= 1'b0;
      pg_d_r  <= 1'b0;
    end else begin
      pg_s1_r <= pg_i;
      pg_s2_r <= pg_s1_r;
      pg_d_r  <= pg_s2_r;
    end
  end

  assign start_w = pg_s2_r && !pg_d_r;

  // Divider restarts on power good so every wait is exact in ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || start_w) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_r == 16'(HALF_MS_CYC - 1)) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b1; // RULE_08
    end else begin
      div_r  <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Rail sequencers
  // ----------------------------------------------------------------
  logic [2:0] rail_code [4];

  assign rail_code[0] =
    ramp_time_rails_one_two_r[`RRS_F_HI_MSB:`RRS_F_HI_LSB];
  assign rail_code[1] =
    ramp_time_rails_one_two_r[`RRS_F_MID_MSB:`RRS_F_MID_LSB];
  assign rail_code[2] =
    ramp_time_rails_three_four_r[`RRS_F_HI_MSB:`RRS_F_HI_LSB];
  assign rail_code[3] =
    ramp_time_rails_three_four_r[`RRS_F_MID_MSB:`RRS_F_MID_LSB];

  for (genvar g = 0; g < 4; g++) begin : g_rail
    rrs_if rif ();
    assign rif.tick  = tick_r;
    assign rif.start = start_w;
    assign rif.pg    = pg_s2_r;
    // Bit 7 is reserved and never reaches the counter
    assign rif.delay = start_delay_r[g][`RRS_F_DLY_MSB:0]; // RULE_07 RULE_10
    assign rif.code  = rail_code[g]; // RULE_09
    assign rail_en_o[g]      = rif.en;
    assign rail_ramping_o[g] = rif.busy;
    assign rail_up_o[g]      = rif.done;

    rrs_rail_seq u_seq (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ctl   (rif.seq)
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wr_ramp_low: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    reg_we_i && reg_addr_i == `RRS_ADDR_RAMP12 |=> ##1
    ramp_duration_rail_one_o == $past(reg_wdata_i[7:5], 2) &&
    ramp_duration_rail_two_o == $past(reg_wdata_i[4:2], 2))
    else $error("rail one or two ramp code wrong");

  a_wr_ramp_mid: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    reg_we_i && reg_addr_i == `RRS_ADDR_RAMP34 |=> ##1
    ramp_duration_rail_three_o == $past(reg_wdata_i[7:5], 2) &&
    ramp_duration_rail_four_o == $past(reg_wdata_i[4:2], 2))
    else $error("rail three or four ramp code wrong");

  a_wr_ramp_lin: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
    reg_we_i && reg_addr_i == `RRS_ADDR_RAMP5L |=> ##1
    ramp_duration_rail_five_o == $past(reg_wdata_i[7:5], 2) &&
    ramp_duration_linear_reg_o == $past(reg_wdata_i[4:3], 2))
    else $error("rail five or linear ramp code wrong");

  // One idle cycle between write and read, as the host leaves it
  a_read_back: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    reg_we_i && reg_addr_i == `RRS_ADDR_DLY1 ##1 !reg_we_i ##1
    reg_re_i && !reg_we_i && reg_addr_i == `RRS_ADDR_DLY1 |=>
    reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("start delay read back mismatch");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_re_i && (reg_addr_i < `RRS_ADDR_RAMP12 ||
    reg_addr_i > `RRS_ADDR_DLY4) |=> reg_rdata_o == `RRS_RD_NONE)
    else $error("unmapped read not zero");

  a_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    tick_r |=> !tick_r)
    else $error("tick wider than one cycle");

endmodule
`default_nettype wire

// file: test/rrs_host_model.sv
// Register host model driving the byte strobe port of the block
`timescale 1ns/1ps
`default_nettype none
module rrs_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_we_o,
  output logic            reg_re_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'hA5;
    reg_we_o    = 1'b0;
    reg_re_o    = 1'b0;
  end

  // Released lines flip so a stale value never passes for a live one
  task automatic idle();
    reg_addr_o  = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_we_o    = 1'b1;
    @(posedge clk_i);
    #1;
    reg_we_o = 1'b0;
    idle();
  endtask

  // Answer is registered on the taking edge and read just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_re_o   = 1'b1;
    @(posedge clk_i);
    #1;
    reg_re_o = 1'b0;
    ok       = reg_rvalid_i;
    d        = reg_rdata_i;
    idle();
  endtask
endmodule
`default_nettype wire

// file: test/rrs_top_tb.sv
// Self-checking testbench for the rail ramp and start delay block
`timescale 1ns/1ps
`default_nettype none
`include "rrs_defs.svh"
module rrs_top_tb;
  // Short tick keeps a 127 ms wait near a thousand cycles
  localparam int H = 4;
  logic       clk_i;
  logic       rst_i;
  logic       pg_i;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       we;
  logic       re;
  logic       rvalid;
  logic [2:0] r1, r2, r3, r4, r5;
  logic [1:0] rl;
  logic [3:0] en, ramping, up;
  logic [7:0] seed;
  logic [7:0] v47, v48, v49;
  logic [6:0] dly [4];
  logic [2:0] cod [4];
  int         num_errors;
  int         n_checks;

  rrs_top #(.HALF_MS_CYC(H)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .pg_i(pg_i),
    .ramp_duration_rail_one_o(r1), .ramp_duration_rail_two_o(r2),
    .ramp_duration_rail_three_o(r3), .ramp_duration_rail_four_o(r4),
    .ramp_duration_rail_five_o(r5), .ramp_duration_linear_reg_o(rl),
    .rail_en_o(en), .rail_ramping_o(ramping), .rail_up_o(up));

  rrs_host_model host_u (
    .clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_we_o(we), .reg_re_o(re), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic int ticks(input logic [2:0] c);
    case (c)
      3'h4:    return 8;
      3'h5:    return 12;
      3'h6:    return 16;
      3'h7:    return 20;
      default: return int'(c) + 1;
    endcase
  endfunction

  function automatic logic [15:0] in_tol(input int v, e, t);
    return 16'((v >= e - t) && (v <= e + t));
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host_u.rd(a, d, ok);
    chk(16'(ok), 16'h0001);
    chk(16'(d), 16'(exp));
  endtask

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Wait counts from power good; ramp length follows the rail's code
  task automatic run_seq();
    int en_t [4];
    int up_t [4];
    int cyc;
    en_t = '{-1, -1, -1, -1};
    up_t = '{-1, -1, -1, -1};
    for (int r = 0; r < 4; r++)
      host_u.wr(8'(8'h4A + r), {seed[r], dly[r]});
    host_u.wr(`RRS_ADDR_RAMP12, {cod[0], cod[1], 2'h3});
    host_u.wr(`RRS_ADDR_RAMP34, {cod[2], cod[3], 2'h0});
    @(posedge clk_i);
    #1 pg_i = 1'b1;
    for (cyc = 1; cyc < 1400 && up !== 4'hF; cyc++) begin
      @(posedge clk_i);
      #1;
      for (int r = 0; r < 4; r++) begin
        if (en_t[r] < 0 && en[r] === 1'b1) en_t[r] = cyc;
        if (up_t[r] < 0 && up[r] === 1'b1) up_t[r] = cyc;
      end
      chk(16'(ramping), 16'(en & ~up));
    end
    for (int r = 0; r < 4; r++) begin
      chk(in_tol(en_t[r], 2 * dly[r] * H + 4, 2), 16'h0001);
      chk(in_tol(up_t[r] - en_t[r], ticks(cod[r]) * H, 1), 16'h0001);
    end
    chk(16'({en, ramping}), 16'h00F0);
    @(posedge clk_i);
    #1 pg_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk(16'({en, ramping, up}), 16'h0000);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    num_errors = 0;
    n_checks   = 0;
    seed       = 8'h21;
    pg_i       = 1'b0;
    rst_i      = 1'b1;
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'b0;
    for (int a = 8'h46; a <= 8'h4E; a++)
      rdchk(8'(a), 8'h00);
    chk(16'({r1, r2, r3, r4, r5}), 16'h0000);
    chk(16'(rl), 16'h0000);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      v47  = {k[2:0], 3'(7 - k), seed[1:0]};
      v48  = {3'(7 - k), k[2:0], seed[3:2]};
      v49  = {k[2:0], k[1:0], seed[6:4]};
      host_u.wr(`RRS_ADDR_RAMP12, v47);
      host_u.wr(`RRS_ADDR_RAMP34, v48);
      host_u.wr(`RRS_ADDR_RAMP5L, v49);
      @(posedge clk_i);
      #1;
      chk(16'(r1), 16'(v47[7:5]));
      chk(16'(r2), 16'(v47[4:2]));
      chk(16'(r3), 16'(v48[7:5]));
      chk(16'(r4), 16'(v48[4:2]));
      chk(16'(r5), 16'(v49[7:5]));
      chk(16'(rl), 16'(v49[4:3]));
      rdchk(`RRS_ADDR_RAMP12, v47);
      rdchk(`RRS_ADDR_RAMP5L, v49);
    end
    for (int r = 0; r < 4; r++) begin
      seed = lfsr(seed);
      host_u.wr(8'(8'h4A + r), seed);
      rdchk(8'(8'h4A + r), seed);
    end
    // Corner pass: zero, one and full-scale waits, extreme codes
    dly = '{7'h00, 7'h01, 7'h7F, 7'(seed[3:0])};
    cod = '{3'h0, 3'h7, seed[2:0], seed[5:3]};
    run_seq();
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rdchk(`RRS_ADDR_RAMP12, 8'h00);
    rdchk(`RRS_ADDR_DLY3, 8'h00);
    for (int r = 0; r < 4; r++) begin
      seed   = lfsr(seed);
      dly[r] = 7'(seed[4:0]);
      cod[r] = seed[7:5];
    end
    run_seq();
    conclude();
  end

  initial begin
    #300000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
